// ---- hdl/iepl_irq_block.sv ----
`timescale 1ns/1ps
// Contract
// - first enable register at index 08h.
// - second enable register at index 09h.
// - enable-low bit 7 inverts the pin level.
// - enable-low bit 6 gates the high-alert request.
// - enable-low bit 5 gates the low-alert request.
// - enable-low bit 4 gates the command-done request.
// - enable-low bit 3 gates the transmit-done request.
// - enable-low bit 2 gates the receive-done request.
// - enable-low bit 1 gates the error request.
// - enable-low bit 0 gates the frame-start request.
// - enable-high bit 7 selects push-pull, else open-drain.
// - enable-high bit 6 passes the combined request to the pin.
// - enable-high bit 5 gates the card-detect request.
// - enable-high bits 4..0 gate timer 4..0 underflow requests.
// - both enable registers read back the last value written.
// - combined request is set when any enabled request is active.
// - error request rises when any listed error flag is set.
// - request writes: bit 7 picks set or clear, ones in 6..0 act (5..0 for the high register).
module iepl_irq_block
  import iepl_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // request event pulses from the sources and error flag levels (rising edges detected), same clock
  input  wire logic [6:0]  low_event,
  input  wire logic [5:0]  high_event,
  input  wire logic [7:0]  contactless_error_flags,
  // interrupt pin and combined request
  output logic             irq_pin_o,
  output logic             irq_pin_oe,
  output logic             combined_request
);
  logic [7:0]  en_low_q, en_high_q;
  logic [6:0]  req_low_q, req_low_d;
  logic [5:0]  req_high_q, req_high_d;
  logic [7:0]  err_prev_q;
  logic        comb_q, pin_o_q, pin_oe_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;

  wire        setup      = psel & ~penable;
  wire        wr_acc     = psel & penable & pwrite & pready_q;
  wire        addr_hi_ok = (paddr[11:10] == 2'b00);
  wire [9:0]  a          = paddr[9:0];
  wire        hit_rl     = addr_hi_ok && a == IEPL_ADDR_REQ_LOW;
  wire        hit_rh     = addr_hi_ok && a == IEPL_ADDR_REQ_HIGH;
  wire        hit_el     = addr_hi_ok && a == IEPL_ADDR_EN_LOW;
  wire        hit_eh     = addr_hi_ok && a == IEPL_ADDR_EN_HIGH;
  wire        hit_er     = addr_hi_ok && a == IEPL_ADDR_ERR;
  wire        mapped     = hit_rl | hit_rh | hit_el | hit_eh | hit_er;
  wire        set_mode   = pwdata[IEPL_BIT_SETMODE];
  wire [7:0]  err_rise   = contactless_error_flags & ~err_prev_q & IEPL_ERR_REQ_MASK;
  wire        err_event  = |err_rise;
  wire [6:0]  low_src    = {low_event[6:2], low_event[1] | err_event, low_event[0]};
  wire [6:0]  wr_rl      = (wr_acc && hit_rl) ? pwdata[6:0] : 7'h00;
  wire [5:0]  wr_rh      = (wr_acc && hit_rh) ? pwdata[5:0] : 6'h00;
  wire        en_any     = |(req_low_d & en_low_q[6:0]) | |(req_high_d & en_high_q[5:0]);
  wire        pin_level  = (comb_q & en_high_q[IEPL_BIT_PIN_EN]) ^ en_low_q[IEPL_BIT_INVERT];
  wire        pin_oe_d   = en_high_q[IEPL_BIT_PUSH_PULL] | ~pin_level;
  wire [7:0]  rd_sel     = hit_rl ? {1'b0, req_low_q} :
                           hit_rh ? {1'b0, comb_q, req_high_q} :
                           hit_el ? en_low_q :
                           hit_eh ? en_high_q :
                           hit_er ? contactless_error_flags : 8'h00;

  // set wins over clear: source events are ORed in after the clear
  always_comb begin
    req_low_d  = set_mode ? (req_low_q | wr_rl) : (req_low_q & ~wr_rl);
    req_low_d  = req_low_d | low_src;
    req_high_d = set_mode ? (req_high_q | wr_rh) : (req_high_q & ~wr_rh);
    req_high_d = req_high_d | high_event;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_low_q  <= IEPL_RST_EN;
      en_high_q <= IEPL_RST_EN;
    end else if (wr_acc && hit_el) begin
      en_low_q  <= pwdata[7:0];
    end else if (wr_acc && hit_eh) begin
      en_high_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_low_q  <= IEPL_RST_REQ;
      req_high_q <= 6'h00;
      err_prev_q <= 8'h00;
    end else begin
      req_low_q  <= req_low_d;
      req_high_q <= req_high_d;
      err_prev_q <= contactless_error_flags;
    end
  end

  // combined request follows the enabled stored flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comb_q <= 1'b0;
    end else begin
      comb_q <= en_any;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_q  <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_o_q  <= pin_level;
      pin_oe_q <= pin_oe_d;
    end
  end

  // no wait state: ready rises in the first access cycle, read data latched with it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q  <= pwrite ? 32'h00000000 : {24'h000000, rd_sel};
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign irq_pin_o        = pin_o_q;
  assign irq_pin_oe       = pin_oe_q;
  assign combined_request = comb_q;

  a_enable_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_el) |=> (en_low_q == $past(pwdata[7:0])))
    else $error("enable low readback wrong");

  a_enable_high_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_eh) |=> (en_high_q == $past(pwdata[7:0])))
    else $error("enable high write lost");

  a_combined_rise: assert property (@(posedge clk) disable iff (!rst_n)
    (|(req_low_q & en_low_q[6:0])) |-> ##[0:1] comb_q)
    else $error("combined request missing");

  a_combined_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (en_low_q[6:0] == 7'h00 && en_high_q[5:0] == 6'h00) |=> !comb_q)
    else $error("combined without enabled source");

  a_timer_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (|(req_high_d & en_high_q[5:0])) |=> comb_q)
    else $error("timer request not propagated");

  a_err_request: assert property (@(posedge clk) disable iff (!rst_n)
    err_event |=> req_low_q[IEPL_BIT_ERR_REQ])
    else $error("error request not raised");

  a_req_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_rl && !set_mode && pwdata[6] && !low_src[6]) |=> !req_low_q[6])
    else $error("clear write ignored");

  a_req_set: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_rh && set_mode && pwdata[0]) |=> req_high_q[0])
    else $error("set write ignored");

  a_pin_level: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 irq_pin_o == (($past(comb_q) & $past(en_high_q[IEPL_BIT_PIN_EN]))
                      ^ $past(en_low_q[IEPL_BIT_INVERT])))
    else $error("pin level wrong");

  a_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_pin_oe && !$past(en_high_q[IEPL_BIT_PUSH_PULL])) |-> !irq_pin_o)
    else $error("open drain drove high");

  // per-source gating: a stored, enabled flag with no bus write must raise the combined request
  a_high_alert_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q[6] && en_low_q[6] && !wr_acc) |=> comb_q)
    else $error("high alert not propagated");

  a_low_alert_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q[5] && en_low_q[5] && !wr_acc) |=> comb_q)
    else $error("low alert not propagated");

  a_cmd_done_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q[4] && en_low_q[4] && !wr_acc) |=> comb_q)
    else $error("command done not propagated");

  a_tx_done_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q[3] && en_low_q[3] && !wr_acc) |=> comb_q)
    else $error("transmit done not propagated");

  a_rx_done_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q[2] && en_low_q[2] && !wr_acc) |=> comb_q)
    else $error("receive done not propagated");

  a_error_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q[1] && en_low_q[1] && !wr_acc) |=> comb_q)
    else $error("error request not propagated");

  a_frame_start_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q[0] && en_low_q[0] && !wr_acc) |=> comb_q)
    else $error("frame start not propagated");

  a_card_detect_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (req_high_q[5] && en_high_q[5] && !wr_acc) |=> comb_q)
    else $error("card detect not propagated");

  a_timer_stored_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ((|(req_high_q[4:0] & en_high_q[4:0])) && !wr_acc) |=> comb_q)
    else $error("stored timer request not propagated");

  a_combined_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (req_low_q == 7'h00 && req_high_q == 6'h00 && low_event == 7'h00
     && high_event == 6'h00 && !err_event && !wr_acc) |=> !comb_q)
    else $error("combined request without source");

  // pin behaviour
  a_invert_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (en_low_q[IEPL_BIT_INVERT] && !en_high_q[IEPL_BIT_PIN_EN]) |=> irq_pin_o)
    else $error("inverted idle level wrong");

  a_pin_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    (!en_low_q[IEPL_BIT_INVERT] && !en_high_q[IEPL_BIT_PIN_EN]) |=> !irq_pin_o)
    else $error("disabled pin went active");

  a_push_pull_oe: assert property (@(posedge clk) disable iff (!rst_n)
    en_high_q[IEPL_BIT_PUSH_PULL] |=> irq_pin_oe)
    else $error("push pull pin not driven");

  a_open_drain_off: assert property (@(posedge clk) disable iff (!rst_n)
    (!en_high_q[IEPL_BIT_PUSH_PULL] && pin_level) |=> !irq_pin_oe)
    else $error("open drain drove high level");

  // register storage
  a_en_low_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_acc && hit_el) |=> $stable(en_low_q))
    else $error("enable low changed without write");

  a_en_high_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_acc && hit_eh) |=> $stable(en_high_q))
    else $error("enable high changed without write");

  a_en_low_read: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && hit_el) |=> (prdata[7:0] == $past(en_low_q)))
    else $error("enable low read wrong");

  a_en_high_read: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && hit_eh) |=> (prdata[7:0] == $past(en_high_q)))
    else $error("enable high read wrong");

  // request flag storage, set wins over a same-cycle clear
  a_low_event_kept: assert property (@(posedge clk) disable iff (!rst_n)
    low_event[6] |=> req_low_q[6])
    else $error("low event lost");

  a_high_event_kept: assert property (@(posedge clk) disable iff (!rst_n)
    high_event[0] |=> req_high_q[0])
    else $error("high event lost");

  a_req_set_low: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_rl && set_mode && pwdata[6]) |=> req_low_q[6])
    else $error("low set write ignored");

  a_req_clear_high: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_rh && !set_mode && pwdata[0] && !high_event[0]) |=> !req_high_q[0])
    else $error("high clear write ignored");

  // bus answer
  a_ready_after_setup: assert property (@(posedge clk) disable iff (!rst_n)
    setup |=> pready)
    else $error("ready missing after setup");

  a_ready_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("ready held too long");

  a_slverr_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !mapped) |=> pslverr)
    else $error("unmapped access not flagged");

  a_slverr_mapped: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && mapped) |=> !pslverr)
    else $error("mapped access flagged");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !pready |-> (prdata == 32'h00000000))
    else $error("read data outside access");

  a_rdata_write: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && pwrite) |=> (prdata == 32'h00000000))
    else $error("read data on write");
endmodule

// ---- hdl/iepl_pkg.sv ----
package iepl_pkg;
  // byte addresses (index * 4): printed offsets 06h..0ah are not all multiples of four
  localparam logic [7:0] IEPL_IDX_REQ_LOW  = 8'h06;
  localparam logic [7:0] IEPL_IDX_REQ_HIGH = 8'h07;
  localparam logic [7:0] IEPL_IDX_EN_LOW   = 8'h08;
  localparam logic [7:0] IEPL_IDX_EN_HIGH  = 8'h09;
  localparam logic [7:0] IEPL_IDX_ERR      = 8'h0a;
  localparam logic [9:0] IEPL_ADDR_REQ_LOW  = {IEPL_IDX_REQ_LOW, 2'b00};
  localparam logic [9:0] IEPL_ADDR_REQ_HIGH = {IEPL_IDX_REQ_HIGH, 2'b00};
  localparam logic [9:0] IEPL_ADDR_EN_LOW   = {IEPL_IDX_EN_LOW, 2'b00};
  localparam logic [9:0] IEPL_ADDR_EN_HIGH  = {IEPL_IDX_EN_HIGH, 2'b00};
  localparam logic [9:0] IEPL_ADDR_ERR      = {IEPL_IDX_ERR, 2'b00};
  // field positions
  localparam int IEPL_BIT_SETMODE   = 7;
  localparam int IEPL_BIT_INVERT    = 7;
  localparam int IEPL_BIT_PUSH_PULL = 7;
  localparam int IEPL_BIT_PIN_EN    = 6;
  localparam int IEPL_BIT_COMBINED  = 6;
  localparam int IEPL_BIT_ERR_REQ   = 1;
  // error sources feeding the error request: write-busy, overflow, no-data, protocol, integrity
  localparam logic [7:0] IEPL_ERR_REQ_MASK = 8'h6b;
  // reset values
  localparam logic [7:0] IEPL_RST_EN   = 8'h00;
  localparam logic [6:0] IEPL_RST_REQ  = 7'h00;
endpackage

// ---- bench/iepl_host_model.sv ----
`timescale 1ns/1ps
module iepl_host_model (
  // pin as driven by the device
  input  wire logic irq_pin_o,
  input  wire logic irq_pin_oe,
  // level seen by the host, pulled up when released
  output logic      pin_level
);
  assign pin_level = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule

// ---- bench/iepl_irq_block_tb.sv ----
`timescale 1ns/1ps
module iepl_irq_block_tb;
  import iepl_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pin_o, pin_oe, comb, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  low_ev;
  logic [5:0]  high_ev;
  logic [7:0]  err_fl;
  logic        rd_err;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  iepl_irq_block dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_event(low_ev), .high_event(high_ev),
    .contactless_error_flags(err_fl), .irq_pin_o(pin_o), .irq_pin_oe(pin_oe),
    .combined_request(comb));
  iepl_host_model host (.irq_pin_o(pin_o), .irq_pin_oe(pin_oe), .pin_level(pin));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, a};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [6:0] l, input logic [5:0] h);
    low_ev <= l;
    high_ev <= h;
    @(posedge clk);
    low_ev <= 7'h00;
    high_ev <= 6'h00;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs();
    apb(1'b0, IEPL_ADDR_EN_LOW, 8'h00);
    chk("en_low reset", 32'h0, rd);
    apb(1'b1, IEPL_ADDR_EN_LOW, 8'h5a);
    apb(1'b1, IEPL_ADDR_EN_HIGH, 8'ha5);
    apb(1'b0, IEPL_ADDR_EN_LOW, 8'h00);
    chk("en_low", 32'h5a, rd);
    apb(1'b0, IEPL_ADDR_EN_HIGH, 8'h00);
    chk("en_high", 32'ha5, rd);
    apb(1'b0, 10'h3fc, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, rd_err});
  endtask
  task automatic t_mask(input logic hi);
    for (int i = 0; i < (hi ? 6 : 7); i++) begin
      apb(1'b1, IEPL_ADDR_EN_LOW, hi ? 8'h00 : 8'h01 << i);
      apb(1'b1, IEPL_ADDR_EN_HIGH, hi ? 8'hc0 | (8'h01 << i) : 8'hc0);
      if (hi) pulse(7'h7f, ~(6'h01 << i));
      else pulse(~(7'h01 << i), 6'h3f);
      chk("masked", 32'h0, {31'h0, comb});
      if (hi) pulse(7'h00, 6'h01 << i);
      else pulse(7'h01 << i, 6'h00);
      chk("combined", 32'h1, {31'h0, comb});
      chk("pin", 32'h1, {31'h0, pin});
      apb(1'b1, IEPL_ADDR_REQ_LOW, 8'h7f);
      apb(1'b1, IEPL_ADDR_REQ_HIGH, 8'h3f);
      repeat (2) @(posedge clk);
      chk("cleared", 32'h0, {31'h0, comb});
    end
  endtask
  task automatic t_pin();
    apb(1'b1, IEPL_ADDR_EN_LOW, 8'h82);
    apb(1'b1, IEPL_ADDR_EN_HIGH, 8'h40);
    repeat (2) @(posedge clk);
    chk("inv oe", 32'h0, {31'h0, pin_oe});
    err_fl <= 8'h04;
    repeat (4) @(posedge clk);
    chk("no err req", 32'h0, {31'h0, comb});
    err_fl <= 8'h06;
    repeat (4) @(posedge clk);
    chk("err req", 32'h1, {31'h0, comb});
    chk("od low", 32'h0, {31'h0, pin});
    apb(1'b1, IEPL_ADDR_EN_HIGH, 8'h80);
    repeat (2) @(posedge clk);
    chk("pp oe", 32'h1, {31'h0, pin_oe});
    chk("pin off", 32'h1, {31'h0, pin_o});
    err_fl <= 8'h00;
    apb(1'b1, IEPL_ADDR_REQ_LOW, 8'h7f);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, low_ev, high_ev, err_fl} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_mask(1'b0);
    t_mask(1'b1);
    t_pin();
    finish_test();
  end
endmodule
